// ### core/wsw_core.sv
// What this block does
// - an enabled, flagged interrupt source is a wake cause regardless of global enable
// - sleep with a wake cause pending is a no-op; watchdog and flags untouched
// - sleep without pending cause completes: watchdog cleared, TO set, PD cleared
// - watchdog runs when config enable set; cleared enable disables it until reset
// - watchdog time-out while awake raises a full device reset
// - watchdog time-out while asleep wakes the device and execution continues
// - unscaled watchdog period is nominally 18 ms
// - prescaler may be given to the watchdog, ratios up to 1:128
// - clear op or sleep resets watchdog count and its assigned prescaler
// - any watchdog time-out clears the active-low time-out flag
// - prescaler assignment may be changed by firmware at any time
// - any wake from sleep clears the watchdog
// - interrupt wake with global enable clear resumes without vectoring
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "wsw_defs.svh"

module wsw_core #(
  parameter int ADDR_W = 8,
  parameter int WDT_BASE_CYCLES = `WSW_WDT_PERIOD_US * `WSW_CLK_MHZ
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // configuration and core events
  input wire logic WATCHDOG_ENABLE_CFG,
  input wire logic [2:0] IRQ_EVENT,
  input wire logic PERIPH_WAKE,
  // core control
  output logic SLEEPING,
  output logic WAKE,
  output logic VECTOR,
  output logic DEVICE_RESET,
  output logic T0_TICK,
  output logic IRQ
);

  localparam int CW = $clog2(WDT_BASE_CYCLES + 1);

  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] status_q, intctl_q, tcfg_q;
  wsw_pkg::wsw_evt_t evt, evt_stat_q, evt_en_q;
  wsw_pkg::wsw_state_t st_q;
  logic wdt_en_q;
  logic [CW-1:0] base_cnt_q;
  logic [7:0] pres_q;
  logic wake_q, vector_q, dev_rst_q, t0_q;
  logic wr_fire, wr_ok, wr_hit;
  logic rd_fire, rd_hit;
  logic [7:0] rd_val;
  logic clr_req, sleep_req, pending;
  logic prescaler_assign, base_tick, wdt_to, wdt_clear, pres_clear;
  logic [7:0] wdt_mask, t0_mask;

  // write channel capture
  assign S_AXI_AWREADY = !aw_full_q;
  assign S_AXI_WREADY = !w_full_q;
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_ok = wr_fire && wstrb0_q;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (S_AXI_AWVALID && !aw_full_q) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      w_full_q <= 1'b0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (S_AXI_WVALID && !w_full_q) begin
      w_full_q <= 1'b1;
      wdata_q <= S_AXI_WDATA[7:0];
      wstrb0_q <= S_AXI_WSTRB[0];
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  always_comb begin
    unique case (aw_addr_q)
      `WSW_OFF_STATUS, `WSW_OFF_INTCTL, `WSW_OFF_TCFG, `WSW_OFF_OP,
      `WSW_OFF_EVT_STAT, `WSW_OFF_EVT_CLR, `WSW_OFF_EVT_EN: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      bvalid_q <= 1'b0;
      bresp_q <= `WSW_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `WSW_RESP_OKAY : `WSW_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;

  // read channel
  assign S_AXI_ARREADY = !rvalid_q;
  assign rd_fire = S_AXI_ARVALID && !rvalid_q;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    unique case (S_AXI_ARADDR)
      `WSW_OFF_STATUS: rd_val = status_q;
      `WSW_OFF_INTCTL: rd_val = intctl_q;
      `WSW_OFF_TCFG: rd_val = tcfg_q;
      `WSW_OFF_EVT_STAT: rd_val = {4'h0, evt_stat_q};
      `WSW_OFF_EVT_EN: rd_val = {4'h0, evt_en_q};
      `WSW_OFF_OP, `WSW_OFF_EVT_CLR: rd_val = 8'h00;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `WSW_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_val};
      rresp_q <= rd_hit ? `WSW_RESP_OKAY : `WSW_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  // core operations
  assign clr_req = wr_ok && aw_addr_q == `WSW_OFF_OP &&
    wdata_q[`WSW_OP_WATCHDOG_CLEAR_OP];
  assign sleep_req = wr_ok && aw_addr_q == `WSW_OFF_OP &&
    wdata_q[`WSW_OP_SLEEP];
  assign pending = |(intctl_q[`WSW_IC_EN_HI:`WSW_IC_EN_LO] &
    intctl_q[`WSW_IC_FL_HI:`WSW_IC_FL_LO]) || PERIPH_WAKE;

  // interrupt_control: hardware flag set wins over software write
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      intctl_q <= `WSW_INTCTL_RST;
    end else begin
      if (wr_ok && aw_addr_q == `WSW_OFF_INTCTL) begin
        intctl_q <= wdata_q;
      end
      intctl_q[`WSW_IC_FL_HI:`WSW_IC_FL_LO] <= IRQ_EVENT |
        ((wr_ok && aw_addr_q == `WSW_OFF_INTCTL) ?
        wdata_q[`WSW_IC_FL_HI:`WSW_IC_FL_LO] :
        intctl_q[`WSW_IC_FL_HI:`WSW_IC_FL_LO]);
    end
  end

  // timer_config, writable at any time
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      tcfg_q <= `WSW_TCFG_RST;
    end else if (wr_ok && aw_addr_q == `WSW_OFF_TCFG) begin
      tcfg_q <= wdata_q;
    end
  end

  // block events
  always_comb begin
    evt.wdt_reset = wdt_to && st_q == wsw_pkg::WSW_RUN;
    evt.wdt_wake = wdt_to && st_q == wsw_pkg::WSW_SLEEP;
    evt.sleep_nop = sleep_req && pending && st_q == wsw_pkg::WSW_RUN;
    evt.wake = pending && st_q == wsw_pkg::WSW_SLEEP;
  end

  // sleep state
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st_q <= wsw_pkg::WSW_RUN;
    end else begin
      unique case (st_q)
        wsw_pkg::WSW_RUN: begin
          if (sleep_req && !pending) begin
            st_q <= wsw_pkg::WSW_SLEEP;
          end
        end
        wsw_pkg::WSW_SLEEP: begin
          if (evt.wake || evt.wdt_wake) begin
            st_q <= wsw_pkg::WSW_RUN;
          end
        end
      endcase
    end
  end

  // processor_status: TO and PD are hardware owned
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      status_q <= `WSW_STATUS_RST;
    end else begin
      if (wr_ok && aw_addr_q == `WSW_OFF_STATUS) begin
        status_q <= wdata_q;
        status_q[`WSW_ST_TO] <= status_q[`WSW_ST_TO];
        status_q[`WSW_ST_PD] <= status_q[`WSW_ST_PD];
      end
      if (sleep_req && !pending && st_q == wsw_pkg::WSW_RUN) begin
        status_q[`WSW_ST_TO] <= 1'b1;
        status_q[`WSW_ST_PD] <= 1'b0;
      end
      if (wdt_to) begin
        status_q[`WSW_ST_TO] <= 1'b0;
      end
    end
  end

  // watchdog enable held from reset, cannot be changed afterwards
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      wdt_en_q <= WATCHDOG_ENABLE_CFG;
    end
  end

  // shared prescaler and watchdog counter
  assign prescaler_assign = tcfg_q[`WSW_TC_PSA];
  assign wdt_mask = (8'h01 << tcfg_q[`WSW_TC_PS_HI:`WSW_TC_PS_LO]) - 8'h01;
  assign t0_mask = (8'h02 << tcfg_q[`WSW_TC_PS_HI:`WSW_TC_PS_LO]) - 8'h01;
  assign base_tick = base_cnt_q == CW'(WDT_BASE_CYCLES - 1);
  assign wdt_to = wdt_en_q && base_tick &&
    (!prescaler_assign || (pres_q & wdt_mask) == wdt_mask);
  assign wdt_clear = clr_req || (sleep_req && !pending &&
    st_q == wsw_pkg::WSW_RUN) || evt.wake || wdt_to;
  assign pres_clear = (wdt_clear && prescaler_assign) ||
    (wr_ok && aw_addr_q == `WSW_OFF_TCFG && wdata_q[`WSW_TC_PSA] != prescaler_assign);

  always_ff @(posedge CLOCK) begin
    if (RESET || !wdt_en_q || wdt_clear || base_tick) begin
      base_cnt_q <= '0;
    end else begin
      base_cnt_q <= base_cnt_q + CW'(1);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET || pres_clear) begin
      pres_q <= 8'h00;
    end else if (prescaler_assign ? base_tick : 1'b1) begin
      pres_q <= pres_q + 8'h01;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      t0_q <= 1'b0;
    end else begin
      t0_q <= !prescaler_assign && (pres_q & t0_mask) == t0_mask;
    end
  end

  // core control pulses
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      wake_q <= 1'b0;
      vector_q <= 1'b0;
      dev_rst_q <= 1'b0;
    end else begin
      wake_q <= evt.wake || evt.wdt_wake;
      vector_q <= evt.wake && intctl_q[`WSW_IC_GIE];
      dev_rst_q <= evt.wdt_reset;
    end
  end

  assign SLEEPING = st_q == wsw_pkg::WSW_SLEEP;
  assign WAKE = wake_q;
  assign VECTOR = vector_q;
  assign DEVICE_RESET = dev_rst_q;
  assign T0_TICK = t0_q;

  // event status, clear and enable; set wins over clear
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      evt_stat_q <= '0;
    end else if (wr_ok && aw_addr_q == `WSW_OFF_EVT_CLR) begin
      evt_stat_q <= (evt_stat_q & ~wsw_pkg::wsw_evt_t'(wdata_q[3:0])) | evt;
    end else begin
      evt_stat_q <= evt_stat_q | evt;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      evt_en_q <= '0;
    end else if (wr_ok && aw_addr_q == `WSW_OFF_EVT_EN) begin
      evt_en_q <= wsw_pkg::wsw_evt_t'(wdata_q[3:0]);
    end
  end

  assign IRQ = |(evt_stat_q & evt_en_q);

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  sleep_nop_a: assert property (sleep_req && pending && !SLEEPING |=>
    !SLEEPING && $stable(status_q[`WSW_ST_TO]) &&
    $stable(status_q[`WSW_ST_PD]))
    else $error("sleep with pending wake did not act as no-op");
  sleep_enter_a: assert property (sleep_req && !pending && !SLEEPING |=>
    SLEEPING && status_q[`WSW_ST_TO] && !status_q[`WSW_ST_PD] &&
    base_cnt_q == '0)
    else $error("sleep did not complete correctly");
  int_wake_a: assert property (SLEEPING && pending |=>
    !SLEEPING && WAKE && base_cnt_q == '0)
    else $error("pending interrupt did not wake and clear watchdog");
  wdt_off_a: assert property (!wdt_en_q |-> ##1 base_cnt_q == '0
    ##1 !DEVICE_RESET)
    else $error("disabled watchdog is counting");
  wdt_reset_a: assert property (wdt_to && !SLEEPING |=>
    DEVICE_RESET && !status_q[`WSW_ST_TO])
    else $error("awake time-out did not reset or clear TO");
  wdt_wake_a: assert property (wdt_to && SLEEPING |=>
    !SLEEPING && WAKE && !DEVICE_RESET && !status_q[`WSW_ST_TO])
    else $error("asleep time-out did not wake");
  clr_cnt_a: assert property (clr_req && !wdt_to |=>
    base_cnt_q == '0 && (!$past(prescaler_assign) || pres_q == 8'h00))
    else $error("clear op did not reset watchdog");
  no_vector_a: assert property (SLEEPING && pending &&
    !intctl_q[`WSW_IC_GIE] |=> WAKE && !VECTOR)
    else $error("wake vectored with global enable clear");
  psa_excl_a: assert property (prescaler_assign |=> !T0_TICK)
    else $error("timer tick while prescaler owns watchdog");

  nop_c: cover property (sleep_req && pending && !SLEEPING);
  int_wake_c: cover property (SLEEPING && pending);
  wdt_wake_c: cover property (wdt_to && SLEEPING);
  wdt_reset_c: cover property (wdt_to && !SLEEPING);

endmodule

`default_nettype wire

// ### shared/wsw_defs.svh
`ifndef WSW_DEFS_SVH
`define WSW_DEFS_SVH

// register byte offsets
`define WSW_OFF_STATUS 8'h00
`define WSW_OFF_INTCTL 8'h04
`define WSW_OFF_TCFG 8'h08
`define WSW_OFF_OP 8'h0c
`define WSW_OFF_EVT_STAT 8'h10
`define WSW_OFF_EVT_CLR 8'h14
`define WSW_OFF_EVT_EN 8'h18

// processor_status fields
`define WSW_ST_TO 4
`define WSW_ST_PD 3
`define WSW_STATUS_RST 8'h18

// interrupt_control fields
`define WSW_IC_GIE 7
`define WSW_IC_EN_HI 5
`define WSW_IC_EN_LO 3
`define WSW_IC_FL_HI 2
`define WSW_IC_FL_LO 0
`define WSW_INTCTL_RST 8'h00

// timer_config fields
`define WSW_TC_PSA 3
`define WSW_TC_PS_HI 2
`define WSW_TC_PS_LO 0
`define WSW_TCFG_RST 8'hff

// operation register fields
`define WSW_OP_WATCHDOG_CLEAR_OP 0
`define WSW_OP_SLEEP 1

// timing
`define WSW_CLK_MHZ 25
`define WSW_WDT_PERIOD_US 18000

// bus answers
`define WSW_RESP_OKAY 2'h0
`define WSW_RESP_SLVERR 2'h2

`endif

// ### shared/wsw_pkg.sv
package wsw_pkg;

  typedef enum logic {
    WSW_RUN,
    WSW_SLEEP
  } wsw_state_t;

  // one bit per block event, same layout in status, clear and enable
  typedef struct packed {
    logic wake;
    logic sleep_nop;
    logic wdt_wake;
    logic wdt_reset;
  } wsw_evt_t;

endpackage

// ### sim/watchdog_sleep_wake_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "wsw_defs.svh"

module watchdog_sleep_wake_test;
  logic clk, rst, wdt_cfg, periph_wake;
  logic [2:0] irq_event;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic sleeping, wake, vector, dev_reset, t0_tick, irq;
  int n_errors, samples_checked;
  int n_wake, n_vec, n_rst, n_tick, w0, v0, r0, t0;

  wsw_core #(.ADDR_W(8), .WDT_BASE_CYCLES(16)) dut (
    .CLOCK(clk), .RESET(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .WATCHDOG_ENABLE_CFG(wdt_cfg), .IRQ_EVENT(irq_event),
    .PERIPH_WAKE(periph_wake), .SLEEPING(sleeping), .WAKE(wake),
    .VECTOR(vector), .DEVICE_RESET(dev_reset), .T0_TICK(t0_tick), .IRQ(irq)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // pulse counters
  always @(posedge clk) begin
    if (wake === 1'b1) n_wake++;
    if (vector === 1'b1) n_vec++;
    if (dev_reset === 1'b1) n_rst++;
    if (t0_tick === 1'b1) n_tick++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  // handshakes sampled at the taking edge, released right after it
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
    logic b_t;
    b_t = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50 && !b_t; i++) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        b_t = 1'b1;
        rs = bresp;
        bready <= 1'b0;
      end
    end
    if (!b_t) begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic axi_read(input logic [7:0] a);
    logic r_t;
    r_t = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50 && !r_t; i++) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        r_t = 1'b1;
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
    if (!r_t) begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic reset_dut(input logic cfg);
    @(posedge clk);
    rst <= 1'b1;
    wdt_cfg <= cfg;
    cycles(6);
    rst <= 1'b0;
  endtask

  // full sleep, then one wake cause for one cycle
  task automatic sleep_wake(input logic [7:0] ic, input logic [2:0] ev,
                            input logic pw, input int vec);
    w0 = n_wake;
    v0 = n_vec;
    axi_write(`WSW_OFF_INTCTL, ic);
    axi_write(`WSW_OFF_OP, 8'h02);
    cycles(2);
    check(sleeping, 1'b1);
    axi_read(`WSW_OFF_STATUS);
    check(rd & 32'h18, 32'h10);
    irq_event <= ev;
    periph_wake <= pw;
    cycles(1);
    irq_event <= 3'h0;
    periph_wake <= 1'b0;
    cycles(4);
    check(n_wake - w0, 1);
    check(n_vec - v0, vec);
    check(sleeping, 1'b0);
  endtask

  initial begin
    rst = 1'b1;
    wdt_cfg = 1'b1;
    periph_wake = 1'b0;
    irq_event = 3'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    reset_dut(1'b1);
    axi_read(`WSW_OFF_STATUS);
    check(rd, `WSW_STATUS_RST);
    axi_read(`WSW_OFF_INTCTL);
    check(rd, `WSW_INTCTL_RST);
    axi_read(`WSW_OFF_TCFG);
    check(rd, `WSW_TCFG_RST);
    axi_read(8'h40);
    check(rs, `WSW_RESP_SLVERR);
    check(rd, 32'h0);
    axi_write(8'h40, 8'h55);
    check(rs, `WSW_RESP_SLVERR);
    // prescaled watchdog kept alive by clear ops, then left to expire
    axi_write(`WSW_OFF_TCFG, 8'h0b);
    r0 = n_rst;
    for (int k = 0; k < 8; k++) begin
      axi_write(`WSW_OFF_OP, 8'h01);
      cycles(100);
    end
    check(n_rst - r0, 0);
    axi_write(`WSW_OFF_OP, 8'h01);
    cycles(110);
    check(n_rst - r0, 0);
    cycles(40);
    check(n_rst - r0, 1);
    axi_read(`WSW_OFF_STATUS);
    check(rd & 32'h18, 32'h08);
    axi_read(`WSW_OFF_EVT_STAT);
    check(rd & 32'h1, 32'h1);
    // prescaler moved to the timer while running
    axi_write(`WSW_OFF_TCFG, 8'h01);
    r0 = n_rst;
    t0 = n_tick;
    cycles(160);
    check((n_tick - t0) inside {[39:41]}, 1'b1);
    check((n_rst - r0) inside {[9:11]}, 1'b1);
    // event status, enable, clear and the interrupt line
    axi_write(`WSW_OFF_TCFG, 8'h0f);
    axi_write(`WSW_OFF_OP, 8'h01);
    axi_write(`WSW_OFF_EVT_EN, 8'h00);
    cycles(1);
    check(irq, 1'b0);
    axi_write(`WSW_OFF_EVT_EN, 8'h01);
    cycles(1);
    check(irq, 1'b1);
    axi_write(`WSW_OFF_EVT_CLR, 8'h0f);
    cycles(1);
    check(irq, 1'b0);
    axi_read(`WSW_OFF_EVT_STAT);
    check(rd, 32'h0);
    // sleep with a cause already pending
    axi_write(`WSW_OFF_EVT_EN, 8'h04);
    w0 = n_wake;
    axi_write(`WSW_OFF_INTCTL, 8'h09);
    axi_write(`WSW_OFF_OP, 8'h02);
    cycles(2);
    check(sleeping, 1'b0);
    check(irq, 1'b1);
    check(n_wake - w0, 0);
    axi_read(`WSW_OFF_STATUS);
    check(rd & 32'h18, 32'h08);
    sleep_wake(8'h08, 3'h1, 1'b0, 0);
    sleep_wake(8'h90, 3'h2, 1'b0, 1);
    sleep_wake(8'h00, 3'h0, 1'b1, 0);
    // watchdog expiry while asleep
    axi_write(`WSW_OFF_TCFG, 8'h08);
    r0 = n_rst;
    w0 = n_wake;
    axi_write(`WSW_OFF_OP, 8'h02);
    cycles(20);
    check(n_wake - w0, 1);
    check(n_rst - r0, 0);
    axi_read(`WSW_OFF_STATUS);
    check(rd & 32'h18, 32'h00);
    // watchdog off from the configuration word
    reset_dut(1'b0);
    axi_write(`WSW_OFF_TCFG, 8'h08);
    r0 = n_rst;
    cycles(100);
    check(n_rst - r0, 0);
    axi_write(`WSW_OFF_OP, 8'h02);
    cycles(60);
    check(sleeping, 1'b1);
    reset_dut(1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
